/* File: hw/fsl_led_driver.sv */
// Status lamp pattern generator for a servo drive with a fieldbus slave.
// Assumes all status inputs are synchronous to core_clk_i; lamps are active high.
`timescale 1ns/1ps
`default_nettype none
module fsl_led_driver #(
  // Bench may shorten the tick; keep it above 8 cycles for the spacing check
  parameter int unsigned TICK_CYCLES = fsl_pkg::TICK_CYC
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic bus_power_i,
  input wire logic drive_enable_i,
  input wire logic drive_fault_i,
  input wire logic [fsl_pkg::PORTS-1:0] link_valid_i,
  input wire logic [fsl_pkg::PORTS-1:0] frame_seen_i,
  input wire logic [2:0] slave_state_i,
  input wire logic fw_download_i,
  input wire logic pdi_wdog_i,
  input wire logic config_error_i,
  input wire logic [7:0] application_layer_state_report_i,
  input wire logic auto_change_i,
  input wire logic app_wdog_i,
  input wire logic alias_net_we_i,
  input wire logic [fsl_pkg::ALIAS_W-1:0] alias_net_i,
  input wire logic alias_setup_we_i,
  input wire logic [fsl_pkg::ALIAS_W-1:0] alias_setup_i,
  output logic [fsl_pkg::ALIAS_W-1:0] alias_o,
  output logic bridge_green_o,
  output logic bridge_red_o,
  output logic [fsl_pkg::PORTS-1:0] port_link_activity_lamp_o,
  output logic network_run_lamp_o,
  output logic error_lamp_o
);
  ////////////////////////////////////////////////////////////////////////////
  // 50 ms tick and pattern phase counters
  logic [22:0] div_q;
  logic tick;
  logic half_q;
  logic blink_q;
  logic [4:0] sgl_q;
  logic [4:0] dbl_q;
  assign tick = (div_q == 23'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 23'h0;
    end else if (tick) begin
      div_q <= 23'h0;
    end else begin
      div_q <= div_q + 23'h1;
    end
  end

  // One free-running set of phases keeps all lamps in step with each other
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_q <= 1'b0;
      blink_q <= 1'b0;
      sgl_q <= 5'h0;
      dbl_q <= 5'h0;
    end else if (tick) begin
      half_q <= ~half_q;
      if (sgl_q[1:0] == 2'h3) begin
        blink_q <= ~blink_q;
      end
      sgl_q <= (sgl_q == 5'(fsl_pkg::SINGLE_LEN - 1)) ? 5'h0 : sgl_q + 5'h1;
      dbl_q <= (dbl_q == 5'(fsl_pkg::DOUBLE_LEN - 1)) ? 5'h0 : dbl_q + 5'h1;
    end
  end

  logic flicker;
  logic blink;
  logic single;
  logic double;
  assign flicker = ~half_q;
  assign blink = ~blink_q;
  assign single = (sgl_q < 5'(fsl_pkg::FLASH_TICKS));
  assign double = (dbl_q < 5'(fsl_pkg::FLASH_TICKS)) ||
                  (dbl_q >= 5'(2 * fsl_pkg::FLASH_TICKS) && dbl_q < 5'(3 * fsl_pkg::FLASH_TICKS));

  ////////////////////////////////////////////////////////////////////////////
  // Bridge lamp; fault wins so red and green never light together
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bridge_green_o <= 1'b0;
      bridge_red_o <= 1'b0;
    end else begin
      bridge_red_o <= drive_fault_i;
      bridge_green_o <= bus_power_i && drive_enable_i && !drive_fault_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link lamps; traffic is remembered for one tick period
  logic [fsl_pkg::PORTS-1:0] act_cur_q;
  logic [fsl_pkg::PORTS-1:0] act_last_q;
  genvar p;
  generate
    for (p = 0; p < fsl_pkg::PORTS; p++) begin : g_port
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          act_cur_q[p] <= 1'b0;
          act_last_q[p] <= 1'b0;
          port_link_activity_lamp_o[p] <= 1'b0;
        end else begin
          if (tick) begin
            act_last_q[p] <= act_cur_q[p] | frame_seen_i[p];
            act_cur_q[p] <= 1'b0;
          end else if (frame_seen_i[p]) begin
            act_cur_q[p] <= 1'b1;
          end
          if (!link_valid_i[p]) begin
            port_link_activity_lamp_o[p] <= 1'b0;
          end else if (act_last_q[p]) begin
            port_link_activity_lamp_o[p] <= flicker;
          end else begin
            port_link_activity_lamp_o[p] <= 1'b1;
          end
        end
      end
      link_dark_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        !link_valid_i[p] |=> !port_link_activity_lamp_o[p])
        else $error("link lamp lit without link");
      link_steady_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (link_valid_i[p] && !act_last_q[p]) |=> port_link_activity_lamp_o[p])
        else $error("link lamp not steady on quiet link");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Network run lamp
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      network_run_lamp_o <= 1'b0;
    end else if (fw_download_i) begin
      network_run_lamp_o <= flicker;
    end else begin
      case (slave_state_i)
        fsl_pkg::SM_OP: network_run_lamp_o <= 1'b1;
        fsl_pkg::SM_PREOP: network_run_lamp_o <= blink;
        fsl_pkg::SM_SAFEOP: network_run_lamp_o <= single;
        fsl_pkg::SM_BOOT, fsl_pkg::SM_BOOTSTRAP: network_run_lamp_o <= flicker;
        fsl_pkg::SM_INIT: network_run_lamp_o <= 1'b0;
        default: network_run_lamp_o <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error lamp in priority order
  logic boot_err;
  assign boot_err = (slave_state_i == fsl_pkg::SM_INIT) &&
                    (application_layer_state_report_i == fsl_pkg::CHANGE_SET);
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      error_lamp_o <= 1'b0;
    end else if (pdi_wdog_i) begin
      error_lamp_o <= 1'b1;
    end else if (app_wdog_i) begin
      error_lamp_o <= double;
    end else if (boot_err) begin
      error_lamp_o <= flicker;
    end else if (config_error_i) begin
      error_lamp_o <= blink;
    end else if (auto_change_i) begin
      error_lamp_o <= single;
    end else begin
      error_lamp_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alias; network write wins when both arrive together
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alias_o <= '0;
    end else if (alias_net_we_i) begin
      alias_o <= alias_net_i;
    end else if (alias_setup_we_i) begin
      alias_o <= alias_setup_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  bridge_red_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    drive_fault_i |=> bridge_red_o && !bridge_green_o)
    else $error("bridge lamp not red in fault");
  bridge_green_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (bus_power_i && drive_enable_i && !drive_fault_i) |=> bridge_green_o)
    else $error("bridge lamp not green");
  run_op_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (slave_state_i == fsl_pkg::SM_OP && !fw_download_i) |=> network_run_lamp_o)
    else $error("run lamp dark in operational");
  run_init_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (slave_state_i == fsl_pkg::SM_INIT && !fw_download_i) |=> !network_run_lamp_o)
    else $error("run lamp lit in init");
  err_pdi_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    pdi_wdog_i |=> error_lamp_o)
    else $error("error lamp not steady on watchdog");
  tick_period_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    tick |=> !tick [*8])
    else $error("tick spacing too short");
  single_len_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (tick && sgl_q == 5'(fsl_pkg::SINGLE_LEN - 1)) |=> sgl_q == 5'h0)
    else $error("single flash period wrong");
  double_gap_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (app_wdog_i && !pdi_wdog_i && dbl_q >= 5'(fsl_pkg::FLASH_TICKS) && dbl_q < 5'(2 * fsl_pkg::FLASH_TICKS))
    |=> !error_lamp_o)
    else $error("double flash gap lit");
  err_priority_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (app_wdog_i && !pdi_wdog_i) |=> error_lamp_o == $past(double))
    else $error("error lamp not showing double flash");
  run_flash_dark_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (slave_state_i == fsl_pkg::SM_SAFEOP && !fw_download_i && sgl_q >= 5'(fsl_pkg::FLASH_TICKS))
    |=> !network_run_lamp_o)
    else $error("run lamp lit in single flash pause");
  alias_setup_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (alias_setup_we_i && !alias_net_we_i) |=> alias_o == $past(alias_setup_i))
    else $error("setup alias not written");
  alias_net_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    alias_net_we_i |=> alias_o == $past(alias_net_i))
    else $error("alias not written");
endmodule : fsl_led_driver
`default_nettype wire

/* File: hw/fsl_pkg.sv */
// Package for the fieldbus status lamp driver: state codes and pattern timing.
// Assumes a 100 MHz core clock; all pattern timing derives from it.
package fsl_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_MS = 50;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FLASH_MS = 200;
  localparam int unsigned PAUSE_MS = 1000;
  localparam int unsigned FLASH_TICKS = FLASH_MS / TICK_MS;
  localparam int unsigned PAUSE_TICKS = PAUSE_MS / TICK_MS;
  localparam int unsigned SINGLE_LEN = FLASH_TICKS + PAUSE_TICKS;
  localparam int unsigned DOUBLE_LEN = 3 * FLASH_TICKS + PAUSE_TICKS;
  localparam int unsigned PORTS = 2;
  localparam int unsigned ALIAS_W = 16;
  localparam logic [7:0] CHANGE_SET = 8'h01;
  typedef enum logic [2:0] {
    SM_BOOT = 3'h0,
    SM_INIT = 3'h1,
    SM_PREOP = 3'h2,
    SM_BOOTSTRAP = 3'h3,
    SM_SAFEOP = 3'h4,
    SM_OP = 3'h5
  } fsl_state_type;
endpackage : fsl_pkg

/* File: verification/fsl_lamp_viewer.sv */
// Operator model: counts how many cycles the run, error and port 0 link lamps are lit since the last clear.
// Assumes lamps are active high and synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module fsl_lamp_viewer (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic err_i,
  input wire logic act_i,
  output logic [7:0] run_cnt_o,
  output logic [7:0] err_cnt_o,
  output logic [7:0] act_cnt_o
);
  // A steady lamp lights every cycle of the window, a dark one none
  always_ff @(posedge clk_i) begin
    run_cnt_o <= clr_i ? 8'h00 : run_cnt_o + {7'h00, run_i};
    err_cnt_o <= clr_i ? 8'h00 : err_cnt_o + {7'h00, err_i};
    act_cnt_o <= clr_i ? 8'h00 : act_cnt_o + {7'h00, act_i};
  end
endmodule : fsl_lamp_viewer
`default_nettype wire

/* File: verification/fsl_led_driver_tb_top.sv */
// Testbench for the status lamp driver: steady levels, priorities and alias writes.
// Assumes the tick is shortened to 10 cycles so whole pattern periods fit the run.
`timescale 1ns/1ps
`default_nettype none
module fsl_led_driver_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, bp = 1'b0, en = 1'b0, flt = 1'b0, fw = 1'b0, pdi = 1'b0;
  logic cfg = 1'b0, ac = 1'b0, aw = 1'b0, nwe = 1'b0, swe = 1'b0, clr = 1'b0;
  logic [1:0] lv = 2'h0, fs = 2'h0, pl;
  logic [2:0] st = 3'h1;
  logic [7:0] alsr = 8'h00, run_cnt, err_cnt, act_cnt;
  logic [15:0] nd = 16'h0000, sd = 16'h0000, alias_val;
  logic bg, br, nr, el;
  int err_count = 0, checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  fsl_led_driver #(.TICK_CYCLES(10)) dut (.core_clk_i(clk), .arst_n_i(rst_n), .bus_power_i(bp),
    .drive_enable_i(en), .drive_fault_i(flt), .link_valid_i(lv), .frame_seen_i(fs), .slave_state_i(st),
    .fw_download_i(fw), .pdi_wdog_i(pdi), .config_error_i(cfg), .application_layer_state_report_i(alsr),
    .auto_change_i(ac), .app_wdog_i(aw), .alias_net_we_i(nwe), .alias_net_i(nd), .alias_setup_we_i(swe),
    .alias_setup_i(sd), .alias_o(alias_val), .bridge_green_o(bg), .bridge_red_o(br),
    .port_link_activity_lamp_o(pl), .network_run_lamp_o(nr), .error_lamp_o(el));
  fsl_lamp_viewer viewer (.clk_i(clk), .clr_i(clr), .run_i(nr), .err_i(el), .act_i(pl[0]), .run_cnt_o(run_cnt),
    .err_cnt_o(err_cnt), .act_cnt_o(act_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  // Settle, clear, then count over whole pattern periods so the free-running phase never matters
  task automatic watch(input int settle, input int n);
    step(settle);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(n);
  endtask : watch
  task automatic wrap_up;
    $display("counts: checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_bridge;
    bp = 1'b1;
    en = 1'b1;
    step(2);
    chk("bridge_green", 16'h0001, {15'h0, bg});
    flt = 1'b1;
    step(2);
    chk("bridge_red", 16'h0001, {15'h0, br});
    chk("bridge_green_fault", 16'h0000, {15'h0, bg});
    flt = 1'b0;
    en = 1'b0;
    step(2);
    chk("bridge_green_off", 16'h0000, {15'h0, bg});
    chk("bridge_red_off", 16'h0000, {15'h0, br});
    $display("bridge test done");
  endtask : t_bridge
  task automatic t_link;
    lv = 2'h1;
    step(2);
    chk("link_lamp_a", 16'h0001, {14'h0, pl});
    lv = 2'h2;
    step(2);
    chk("link_lamp_b", 16'h0002, {14'h0, pl});
    {lv, fs} = {2'h3, 2'h1};
    watch(30, 20);
    chk("link_flicker", 16'h000a, {8'h0, act_cnt});
    chk("link_quiet_port", 16'h0001, {15'h0, pl[1]});
    fs = 2'h0;
    watch(30, 16);
    chk("link_idle", 16'h0010, {8'h0, act_cnt});
    lv = 2'h0;
    step(2);
    chk("link_lamp_off", 16'h0000, {14'h0, pl});
    $display("link test done");
  endtask : t_link
  task automatic t_run;
    st = 3'h5;
    watch(2, 16);
    chk("run_steady", 16'h0010, {8'h0, run_cnt});
    st = 3'h2;
    watch(2, 80);
    chk("run_blink", 16'h0028, {8'h0, run_cnt});
    st = 3'h4;
    watch(2, 240);
    chk("run_single", 16'h0028, {8'h0, run_cnt});
    st = 3'h0;
    watch(2, 20);
    chk("run_boot", 16'h000a, {8'h0, run_cnt});
    st = 3'h3;
    watch(2, 20);
    chk("run_bootstrap", 16'h000a, {8'h0, run_cnt});
    {st, fw} = {3'h5, 1'b1};
    watch(2, 20);
    chk("run_download", 16'h000a, {8'h0, run_cnt});
    {st, fw} = {3'h1, 1'b0};
    watch(2, 16);
    chk("run_dark", 16'h0000, {8'h0, run_cnt});
    $display("run lamp test done");
  endtask : t_run
  // Every error source at once: the interface watchdog must win with steady red
  task automatic t_err;
    {pdi, cfg, ac, aw} = 4'hf;
    alsr = 8'h01;
    watch(2, 16);
    chk("err_steady", 16'h0010, {8'h0, err_cnt});
    pdi = 1'b0;
    watch(2, 320);
    chk("err_double", 16'h0050, {8'h0, err_cnt});
    aw = 1'b0;
    watch(2, 20);
    chk("err_boot_flicker", 16'h000a, {8'h0, err_cnt});
    alsr = 8'h00;
    watch(2, 80);
    chk("err_blink", 16'h0028, {8'h0, err_cnt});
    cfg = 1'b0;
    watch(2, 240);
    chk("err_single", 16'h0028, {8'h0, err_cnt});
    ac = 1'b0;
    watch(2, 16);
    chk("err_dark", 16'h0000, {8'h0, err_cnt});
    $display("error lamp test done");
  endtask : t_err
  task automatic t_alias;
    {nwe, nd} = {1'b1, 16'h1234};
    step(1);
    nwe = 1'b0;
    step(1);
    chk("alias_net", 16'h1234, alias_val);
    {swe, sd} = {1'b1, 16'habcd};
    step(1);
    swe = 1'b0;
    step(1);
    chk("alias_setup", 16'habcd, alias_val);
    {nwe, nd, swe, sd} = {1'b1, 16'h5a5a, 1'b1, 16'hffff};
    step(1);
    chk("alias_net_wins", 16'h5a5a, alias_val);
    nd = 16'h0002;
    swe = 1'b0;
    step(1);
    nwe = 1'b0;
    step(1);
    chk("alias_back_to_back", 16'h0002, alias_val);
    $display("alias test done");
  endtask : t_alias
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  initial begin
    step(4);
    rst_n = 1'b1;
    step(1);
    t_bridge();
    t_link();
    t_run();
    t_err();
    t_alias();
    wrap_up();
  end
endmodule : fsl_led_driver_tb_top
`default_nettype wire
